// File: verilog/tpw_pkg.sv
// package: register map, field layout and types of the pwm timer
package tpw_pkg;

  // register byte offsets
  localparam logic [11:0] ctl0_off = 12'h000;
  localparam logic [11:0] ctl1_off = 12'h004;
  localparam logic [11:0] cnt_off = 12'h008;
  localparam logic [11:0] match_off = 12'h00c;
  localparam logic [11:0] reload_off = 12'h010;
  localparam logic [11:0] dead_off = 12'h014;
  localparam logic [11:0] mask_off = 12'h018;
  localparam logic [11:0] irq_off = 12'hfc0;

  // timer_control_one fields
  localparam int en_bit = 7;
  localparam int pol_bit = 6;
  localparam int presc_lsb = 3;
  localparam int mode_lsb = 0;
  // timer_control_zero field
  localparam int modehi_bit = 7;

  // interrupt_request_zero fields
  localparam int t1_req_bit = 6;
  localparam int t0_req_bit = 5;
  localparam logic [7:0] irq_wmask = 8'h7f;

  // mode codes: {mode_select_high_bit, mode_select_field}
  localparam logic [3:0] mode_pwm_single = 4'h3;
  localparam logic [3:0] mode_pwm_dual = 4'h8;

  localparam logic [15:0] restart_cnt = 16'h0001;
  localparam logic [7:0] ctl_rst = 8'h00;
  localparam logic [15:0] word_rst = 16'h0000;
  localparam logic [15:0] cnt_rst = 16'h0001;
  localparam logic [7:0] irq_rst = 8'h00;
  localparam logic [7:0] mask_rst = 8'h00;

  typedef struct packed {
    logic out;
    logic out_n;
    logic out_n_oe_n;
  } tpw_pins_s;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_first = 3'b010,
    st_run = 3'b100
  } tpw_state_e;

endpackage : tpw_pkg

// File: verilog/tpw_timer.sv
// single and dual output pwm timer with apb registers and request register
// Behaviour
// - single mode counts up, output toggles when count equals 16-bit match
// - at reload raise request, load count 0001h, keep counting
// - counter advances on pclk divided by the prescale value
// - polarity one: start high, low at match, high again at reload
// - polarity zero: start low, high at match, low again at reload
// - software start count only for first pass, later passes from 0001h
// - first pass from another start runs start value to reload
// - period equals reload times prescale over clock frequency
// - dual mode chosen by mode field plus mode high bit
// - dual mode inserts dead-band after each level change before either output asserts
// - dual mode turns shared input pin into complement output
// - a presented request sets its bit of the request register
// - timer one request bit 6, timer zero request bit 5
// - pending unmasked request drives interrupt when globally enabled
//
// Chosen here: register access over APB.
module tpw_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic global_int_en,
  input wire logic timer_one_event,
  input wire logic timer_in_pin,
  output logic timer_in_level,
  output logic irq,
  output tpw_pkg::tpw_pins_s pins
);

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [2:0] presc_sel(input logic [7:0] c);
    presc_sel = c[tpw_pkg::presc_lsb +: 3];
  endfunction

  function automatic logic [7:0] merge_w(input logic [7:0] old, input logic [31:0] d,
                                         input logic hit);
    merge_w = hit ? d[7:0] : old;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] ctl0_r, ctl0_nxt, ctl1_r, ctl1_nxt;
  logic [15:0] cnt_r, cnt_nxt, match_r, match_nxt, reload_r, reload_nxt;
  logic [7:0] dead_r, dead_nxt, mask_r, mask_nxt, irq_r, irq_nxt;
  logic [6:0] pre_r, pre_nxt;
  logic [7:0] db_r, db_nxt;
  logic lvl_r, lvl_nxt, out_r, out_nxt, outn_r, outn_nxt, oen_r, oen_nxt;
  logic irq_out_r, irq_out_nxt, rdy_r, rdy_nxt, err_r, err_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic in_s1_r, in_s2_r, in_lvl_r, in_lvl_nxt;
  logic ev_s1_r, ev_s2_r;
  tpw_pkg::tpw_state_e st_r, st_nxt;

  logic wr, rd, enabled, dual, pwm_mode, tick, at_reload, at_match, hit_known;
  logic [3:0] mode;
  logic [6:0] pre_div;

  assign wr = psel && penable && pwrite && !rdy_r;
  assign rd = psel && penable && !pwrite && !rdy_r;
  assign mode = {ctl0_r[tpw_pkg::modehi_bit], ctl1_r[2:0]};
  assign dual = (mode == tpw_pkg::mode_pwm_dual);
  assign pwm_mode = dual || (mode == tpw_pkg::mode_pwm_single);
  assign enabled = ctl1_r[tpw_pkg::en_bit] && pwm_mode;
  // prescale is 2^sel: 1..128
  assign pre_div = 7'((8'h01 << presc_sel(ctl1_r)) - 8'h01);
  assign tick = enabled && (pre_r == pre_div);
  // reload is checked before match, so a match equal to reload never toggles
  assign at_reload = (cnt_r == reload_r);
  assign at_match = (cnt_r == match_r);
  // unmapped offsets answer with pslverr and read as zero
  assign hit_known = (paddr == tpw_pkg::ctl0_off) || (paddr == tpw_pkg::ctl1_off) ||
    (paddr == tpw_pkg::cnt_off) || (paddr == tpw_pkg::match_off) ||
    (paddr == tpw_pkg::reload_off) || (paddr == tpw_pkg::dead_off) ||
    (paddr == tpw_pkg::mask_off) || (paddr == tpw_pkg::irq_off);

  ////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state
  always_comb begin
    ctl0_nxt = merge_w(ctl0_r, pwdata, wr && paddr == tpw_pkg::ctl0_off);
    ctl1_nxt = merge_w(ctl1_r, pwdata, wr && paddr == tpw_pkg::ctl1_off);
    match_nxt = (wr && paddr == tpw_pkg::match_off) ? pwdata[15:0] : match_r;
    reload_nxt = (wr && paddr == tpw_pkg::reload_off) ? pwdata[15:0] : reload_r;
    dead_nxt = merge_w(dead_r, pwdata, wr && paddr == tpw_pkg::dead_off);
    mask_nxt = merge_w(mask_r, pwdata, wr && paddr == tpw_pkg::mask_off);
    // the wait-state flag stops a second write in the answer cycle
    rdy_nxt = psel && penable && !rdy_r;
    err_nxt = psel && penable && !rdy_r && !hit_known;
    rd_nxt = 32'h0000_0000;
    if (rd) begin
      unique case (paddr)
        tpw_pkg::ctl0_off: rd_nxt = {24'h00_0000, ctl0_r};
        tpw_pkg::ctl1_off: rd_nxt = {24'h00_0000, ctl1_r};
        tpw_pkg::cnt_off: rd_nxt = {16'h0000, cnt_r};
        tpw_pkg::match_off: rd_nxt = {16'h0000, match_r};
        tpw_pkg::reload_off: rd_nxt = {16'h0000, reload_r};
        tpw_pkg::dead_off: rd_nxt = {24'h00_0000, dead_r};
        tpw_pkg::mask_off: rd_nxt = {24'h00_0000, mask_r};
        tpw_pkg::irq_off: rd_nxt = {24'h00_0000, irq_r};
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter, prescaler and waveform
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    // prescaler held at zero while disabled, so each run starts on a full period
    pre_nxt = enabled ? (tick ? 7'h00 : 7'(pre_r + 7'h01)) : 7'h00;
    lvl_nxt = lvl_r;
    if (!enabled) begin
      st_nxt = tpw_pkg::st_idle;
      lvl_nxt = ctl1_r[tpw_pkg::pol_bit];
    end else if (st_r == tpw_pkg::st_idle) begin
      st_nxt = tpw_pkg::st_first;
    end
    if (tick) begin
      if (at_reload) begin
        cnt_nxt = tpw_pkg::restart_cnt;
        lvl_nxt = ctl1_r[tpw_pkg::pol_bit];
        st_nxt = tpw_pkg::st_run;
      end else begin
        cnt_nxt = 16'(cnt_r + 16'h0001);
        if (at_match) begin
          lvl_nxt = !lvl_r;
        end
      end
    end
    // a count write wins over the tick so a start value always lands
    if (wr && paddr == tpw_pkg::cnt_off) begin
      cnt_nxt = pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // dead-band and pins
  always_comb begin
    // every level change restarts the gap, which holds both pins inactive in dual mode only
    if (lvl_nxt != lvl_r) begin
      db_nxt = dead_r;
    end else if (db_r != 8'h00) begin
      db_nxt = 8'(db_r - 8'h01);
    end else begin
      db_nxt = 8'h00;
    end
    oen_nxt = !dual;
    if (!dual) begin
      out_nxt = lvl_r;
      outn_nxt = 1'b0;
    end else if (db_nxt != 8'h00) begin
      out_nxt = 1'b0;
      outn_nxt = 1'b0;
    end else begin
      out_nxt = lvl_r;
      outn_nxt = !lvl_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request register and interrupt
  always_comb begin
    irq_nxt = irq_r;
    if (wr && paddr == tpw_pkg::irq_off) begin
      irq_nxt = irq_r & ~(pwdata[7:0] & tpw_pkg::irq_wmask);
    end
    // sets follow the clear, so an event in the clear cycle is kept
    if (tick && at_reload) begin
      irq_nxt[tpw_pkg::t0_req_bit] = 1'b1;
    end
    if (ev_s2_r) begin
      irq_nxt[tpw_pkg::t1_req_bit] = 1'b1;
    end
    // reserved top bit always reads zero
    irq_nxt[7] = 1'b0;
    irq_out_nxt = global_int_en && |(irq_r & mask_r);
  end

  ////////////////////////////////////////////////////////////////////////
  // shared pin level, read only after the second synchroniser stage
  always_comb begin
    in_lvl_nxt = in_s2_r && !dual;
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl0_r <= tpw_pkg::ctl_rst;
      ctl1_r <= tpw_pkg::ctl_rst;
      match_r <= tpw_pkg::word_rst;
      reload_r <= tpw_pkg::word_rst;
      dead_r <= 8'h00;
      mask_r <= tpw_pkg::mask_rst;
    end else begin
      ctl0_r <= ctl0_nxt;
      ctl1_r <= ctl1_nxt;
      match_r <= match_nxt;
      reload_r <= reload_nxt;
      dead_r <= dead_nxt;
      mask_r <= mask_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_r <= 1'b0;
      err_r <= 1'b0;
      rd_r <= 32'h0000_0000;
    end else begin
      rdy_r <= rdy_nxt;
      err_r <= err_nxt;
      rd_r <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= tpw_pkg::cnt_rst;
      pre_r <= 7'h00;
      lvl_r <= 1'b0;
      st_r <= tpw_pkg::st_idle;
    end else begin
      cnt_r <= cnt_nxt;
      pre_r <= pre_nxt;
      lvl_r <= lvl_nxt;
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      db_r <= 8'h00;
      out_r <= 1'b0;
      outn_r <= 1'b0;
      oen_r <= 1'b1;
    end else begin
      db_r <= db_nxt;
      out_r <= out_nxt;
      outn_r <= outn_nxt;
      oen_r <= oen_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request register and interrupt line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= tpw_pkg::irq_rst;
      irq_out_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
      irq_out_r <= irq_out_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // synchronisers for the pin and the timer one event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_s1_r <= 1'b0;
      in_s2_r <= 1'b0;
      in_lvl_r <= 1'b0;
      ev_s1_r <= 1'b0;
      ev_s2_r <= 1'b0;
    end else begin
      in_s1_r <= timer_in_pin;
      in_s2_r <= in_s1_r;
      in_lvl_r <= in_lvl_nxt;
      ev_s1_r <= timer_one_event;
      ev_s2_r <= ev_s1_r;
    end
  end

  assign prdata = rd_r;
  assign pready = rdy_r;
  assign pslverr = err_r;
  assign irq = irq_out_r;
  assign timer_in_level = in_lvl_r;
  assign pins.out = out_r;
  assign pins.out_n = outn_r;
  assign pins.out_n_oe_n = oen_r;

endmodule // tpw_timer

// File: testbench/tpw_timer_sva.sv
// checker: apb handshake, interrupt line and complement pin of the pwm timer
module tpw_timer_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic global_int_en,
  input wire logic timer_in_level,
  input wire logic irq,
  input wire tpw_pkg::tpw_pins_s pins
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready long");
  a_slverr_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
  a_irq_gated: assert property (!global_int_en |=> !irq)
    else $error("irq while off");
  a_irq_cause: assert property ($rose(irq) |-> $past(global_int_en))
    else $error("irq uncaused");
  a_out_excl: assert property (!(pins.out && pins.out_n))
    else $error("both high");
  a_dead_gap: assert property ($rose(pins.out_n) |-> !$past(pins.out))
    else $error("no dead band");
  a_comp_pin: assert property (pins.out_n |-> !pins.out_n_oe_n && !timer_in_level)
    else $error("pin not switched");
  c_irq: cover property ($rose(irq));
  c_comp: cover property ($rose(pins.out_n));
  c_slverr: cover property (pslverr);
endmodule // tpw_timer_sva

// File: testbench/tpw_load_model.sv
// load model: pull-up on the shared pin, high-phase meter of both outputs
module tpw_load_model (
  input wire logic pclk,
  input wire tpw_pkg::tpw_pins_s pins,
  output logic timer_in_pin,
  output int hi_len,
  output int nhi_len
);
  timeunit 1ns;
  timeprecision 1ns;
  int hi = 0, nhi = 0;
  // pulled up unless the timer drives its complement onto the pin
  assign timer_in_pin = pins.out_n_oe_n ? 1'b1 : pins.out_n;
  always @(posedge pclk) begin
    hi <= pins.out ? hi + 1 : 0;
    nhi <= pins.out_n ? nhi + 1 : 0;
    if (!pins.out && hi != 0) hi_len <= hi;
    if (!pins.out_n && nhi != 0) nhi_len <= nhi;
  end
endmodule // tpw_load_model

// File: testbench/tpw_timer_tb.sv
// testbench: pwm modes, request register and shared pin over apb
module tpw_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic gie = 1'b0, ev = 1'b0, pready, pslverr, pin, tlev, irq, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  tpw_pkg::tpw_pins_s pins;
  int hi_len, nhi_len, miscompares = 0, checks = 0;
  tpw_timer tpw_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .global_int_en(gie), .timer_one_event(ev), .timer_in_pin(pin),
    .timer_in_level(tlev), .irq(irq), .pins(pins));
  tpw_load_model tpw_load_model_inst (.pclk(pclk), .pins(pins), .timer_in_pin(pin),
    .hi_len(hi_len), .nhi_len(nhi_len));
  initial forever #10 pclk = ~pclk;
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    give_verdict();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic cfg(input logic [7:0] c0, c1, input logic [15:0] st, m, r);
    apb(1'b1, tpw_pkg::ctl1_off, 32'h0);
    apb(1'b1, tpw_pkg::ctl0_off, {24'h0, c0});
    apb(1'b1, tpw_pkg::ctl1_off, {24'h0, c1});
    apb(1'b1, tpw_pkg::cnt_off, {16'h0, st});
    apb(1'b1, tpw_pkg::match_off, {16'h0, m});
    apb(1'b1, tpw_pkg::dead_off, 32'h2);
    apb(1'b1, tpw_pkg::reload_off, {16'h0, r});
    apb(1'b1, tpw_pkg::ctl1_off, {24'h0, c1 | 8'h80});
    repeat (80) @(posedge pclk);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(tpw_pkg::irq_off, 32'h0);
    rdchk(12'h7f0, 32'h0);
    chk(err, 1);
    cfg(8'h00, 8'h43, 16'h6, 16'h3, 16'h8);
    chk(hi_len, 3);
    cfg(8'h00, 8'h0b, 16'h1, 16'h3, 16'h8);
    chk(hi_len, 10);
    chk(tlev, 1);
    apb(1'b1, tpw_pkg::mask_off, 32'h20);
    gie <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(irq, 1);
    rdchk(tpw_pkg::irq_off, 32'h20);
    gie <= 1'b0;
    apb(1'b1, tpw_pkg::ctl1_off, 32'h0);
    chk(irq, 0);
    apb(1'b1, tpw_pkg::irq_off, 32'h20);
    rdchk(tpw_pkg::irq_off, 32'h0);
    ev <= 1'b1;
    repeat (3) @(posedge pclk);
    ev <= 1'b0;
    repeat (4) @(posedge pclk);
    rdchk(tpw_pkg::irq_off, 32'h40);
    apb(1'b1, tpw_pkg::irq_off, 32'h40);
    cfg(8'h80, 8'h40, 16'h1, 16'h4, 16'hc);
    chk(hi_len, 2);
    chk(nhi_len, 6);
    chk(tlev, 0);
    give_verdict();
  end
endmodule // tpw_timer_tb
bind tpw_timer tpw_timer_sva tpw_timer_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .global_int_en(global_int_en),
  .timer_in_level(timer_in_level), .irq(irq), .pins(pins));
